// file: inc/irq_ctrl_pkg.sv
// Constants, register map and carrier types of the nested interrupt controller.
package irq_ctrl_pkg;

   // ---------------------------------------------------------------
   // Sizes.
   // ---------------------------------------------------------------
   localparam int IRQ_COUNT = 32;
   localparam int PRIO_W = 4;
   localparam int ID_W = 9;
   localparam logic [ID_W-1:0] ID_LIMIT = 9'h020;

   // ---------------------------------------------------------------
   // Register byte addresses; each bank holds eight words.
   // ---------------------------------------------------------------
   localparam logic [31:0] OFS_EN_SET = 32'he000e100;
   localparam logic [31:0] OFS_EN_CLR = 32'he000e180;
   localparam logic [31:0] OFS_PEND_SET = 32'he000e200;
   localparam logic [31:0] OFS_PEND_CLR = 32'he000e280;
   localparam logic [31:0] OFS_ACTIVE = 32'he000e300;
   localparam logic [31:0] OFS_LEVEL_SEL = 32'he000e380;
   localparam logic [31:0] OFS_PRIO = 32'he000e400;
   localparam logic [31:0] OFS_TRIGGER = 32'he000ef00;
   localparam logic [31:0] BANK_MASK = 32'hffffffe0;

   // ---------------------------------------------------------------
   // Field positions and reset values.
   // ---------------------------------------------------------------
   localparam int PRIO_FIELD_LSB = 4;
   localparam int BYTE_W = 8;
   localparam int TRIG_ID_LSB = 0;
   localparam logic [31:0] PRIO_LOW_NIBBLES = 32'h0f0f0f0f;
   localparam logic [31:0] WORD_RST = 32'h00000000;
   localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;

   // ---------------------------------------------------------------
   // Carriers.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] num;
      logic [PRIO_W-1:0] prio;
   } core_req_s;

   typedef struct packed {
      logic ack;
      logic done;
      logic [ID_W-1:0] done_num;
   } core_rsp_s;

   typedef struct packed {
      logic [IRQ_COUNT-1:0] en;
      logic [IRQ_COUNT-1:0] pend;
      logic [IRQ_COUNT-1:0] act;
      logic [IRQ_COUNT-1:0] level;
      logic [IRQ_COUNT-1:0] line_prev;
      logic [IRQ_COUNT-1:0][PRIO_W-1:0] prio;
      logic [31:0] rdata;
      core_req_s pres;
   } state_s;

   localparam state_s STATE_RST = '0;

endpackage

// file: src/nested_irq_controller.sv
// Enable, pending, active and priority state of the nested interrupt controller.
`timescale 1ns/10ps
`default_nettype none

module nested_irq_controller (
   input wire logic mclk,
   input wire logic resetn,
   input wire irq_ctrl_pkg::bus_req_s bus,
   output var logic [31:0] rdata,
   input wire logic [irq_ctrl_pkg::IRQ_COUNT-1:0] irq_lines,
   input wire irq_ctrl_pkg::core_rsp_s core_rsp,
   output var irq_ctrl_pkg::core_req_s core_req
);
   import irq_ctrl_pkg::*;

   state_s st_q;
   state_s st_d;
   logic [31:0] bemask;
   logic [31:0] wmask;
   logic word0;
   logic [IRQ_COUNT-1:0] sw_set;
   logic [IRQ_COUNT-1:0] trig_set;
   logic [IRQ_COUNT-1:0] edge_set;
   logic [IRQ_COUNT-1:0] level_set;
   logic [IRQ_COUNT-1:0] resample_set;
   logic [IRQ_COUNT-1:0] pend_clr;
   logic [IRQ_COUNT-1:0] ack_mask;
   logic [IRQ_COUNT-1:0] ret_mask;
   logic [IRQ_COUNT-1:0] cand;
   logic best_found;
   logic [ID_W-1:0] best_num;
   logic [PRIO_W-1:0] best_prio;
   logic act_any;
   logic [PRIO_W-1:0] act_min;

   // ---------------------------------------------------------------
   // Bus decode helpers.
   // ---------------------------------------------------------------

   // True when the address falls inside the eight-word bank at base.
   function automatic logic in_bank(input logic [31:0] a,
                                    input logic [31:0] base);
      return (a & BANK_MASK) == base;
   endfunction

   // Byte enables widened to a bit mask; writes other than the trigger only touch enabled lanes.
   assign bemask = {{BYTE_W{bus.be[3]}}, {BYTE_W{bus.be[2]}},
                    {BYTE_W{bus.be[1]}}, {BYTE_W{bus.be[0]}}};
   assign wmask = bus.wdata & bemask;
   // Only the first word of each bit bank is backed; 32 interrupts fit.
   assign word0 = (bus.addr[4:2] == 3'h0);

   // ---------------------------------------------------------------
   // Next state.
   // ---------------------------------------------------------------

   // All state updates live here; one flop process registers the copy.
   always_comb begin
      logic [ID_W-1:0] trig_id;
      trig_id = bus.wdata[TRIG_ID_LSB +: ID_W];
      st_d = st_q;
      st_d.rdata = WORD_RST;

      // Software set and clear masks, gated on the decoded bank.
      sw_set = '0;
      if (bus.wr && in_bank(bus.addr, OFS_PEND_SET) && word0) begin
         sw_set = wmask;
      end
      trig_set = '0;
      if (bus.wr && bus.addr == OFS_TRIGGER && trig_id < ID_LIMIT) begin
         trig_set = 32'h1 << trig_id[4:0];
      end
      // A still-asserted level line keeps its pending state.
      pend_clr = '0;
      if (bus.wr && in_bank(bus.addr, OFS_PEND_CLR) && word0) begin
         pend_clr = wmask & ~(st_q.level & irq_lines);
      end

      // Hardware events from the request lines.
      edge_set = irq_lines & ~st_q.line_prev & ~st_q.level;
      // Edges on level lines are masked above and left to the level term below.
      level_set = st_q.level & irq_lines & ~st_q.act;

      // Core handshake: acceptance of the presented one, handler return.
      ack_mask = '0;
      if (core_rsp.ack && st_q.pres.valid &&
          st_q.pres.num < ID_LIMIT) begin
         ack_mask = (32'h1 << st_q.pres.num[4:0]) & st_q.pend & st_q.en;
      end
      ret_mask = '0;
      if (core_rsp.done && core_rsp.done_num < ID_LIMIT) begin
         ret_mask = 32'h1 << core_rsp.done_num[4:0];
      end
      resample_set = ret_mask & st_q.level & irq_lines;

      // Sets win over clears so that no event is lost in a clear cycle.
      st_d.pend = (st_q.pend & ~pend_clr & ~ack_mask) | sw_set |
                  trig_set | edge_set | level_set | resample_set;
      // The clear-pending path never reaches the active flags.
      st_d.act = (st_q.act | ack_mask) & ~ret_mask;
      st_d.line_prev = irq_lines;

      // Enable set and clear banks, and the level select bank.
      if (bus.wr && in_bank(bus.addr, OFS_EN_SET) && word0) begin
         st_d.en = st_q.en | wmask;
      end
      if (bus.wr && in_bank(bus.addr, OFS_EN_CLR) && word0) begin
         st_d.en = st_q.en & ~wmask;
      end
      if (bus.wr && in_bank(bus.addr, OFS_LEVEL_SEL) && word0) begin
         st_d.level = (st_q.level & ~bemask) | wmask;
      end

      // Priority bytes; only the upper nibble of each lane is kept.
      if (bus.wr && in_bank(bus.addr, OFS_PRIO)) begin
         for (int b = 0; b < 4; b++) begin
            if (bus.be[b]) begin
               st_d.prio[{bus.addr[4:2], 2'(b)}] =
                  bus.wdata[b*BYTE_W + PRIO_FIELD_LSB +: PRIO_W];
            end
         end
      end

      // Read data, returned one cycle after the strobe and only then.
      if (bus.rd) begin
         if (word0 && (in_bank(bus.addr, OFS_EN_SET) ||
                       in_bank(bus.addr, OFS_EN_CLR))) begin
            st_d.rdata = st_q.en;
         end else if (word0 && (in_bank(bus.addr, OFS_PEND_SET) ||
                                in_bank(bus.addr, OFS_PEND_CLR))) begin
            st_d.rdata = st_q.pend;
         end else if (word0 && in_bank(bus.addr, OFS_ACTIVE)) begin
            st_d.rdata = st_q.act;
         end else if (word0 && in_bank(bus.addr, OFS_LEVEL_SEL)) begin
            st_d.rdata = st_q.level;
         end else if (in_bank(bus.addr, OFS_PRIO)) begin
            for (int b = 0; b < 4; b++) begin
               st_d.rdata[b*BYTE_W + PRIO_FIELD_LSB +: PRIO_W] =
                  st_q.prio[{bus.addr[4:2], 2'(b)}];
            end
         end
      end

      // Highest priority candidate; strict compare keeps the lowest number.
      cand = st_q.pend & st_q.en;
      best_found = 1'b0;
      best_num = '0;
      best_prio = PRIO_RST;
      for (int i = 0; i < IRQ_COUNT; i++) begin
         if (cand[i] && (!best_found || st_q.prio[i] < best_prio)) begin
            best_found = 1'b1;
            best_num = ID_W'(i);
            best_prio = st_q.prio[i];
         end
      end
      // Nesting: only a strictly more urgent interrupt may preempt.
      act_any = 1'b0;
      act_min = PRIO_RST;
      for (int i = 0; i < IRQ_COUNT; i++) begin
         if (st_q.act[i] && (!act_any || st_q.prio[i] < act_min)) begin
            act_any = 1'b1;
            act_min = st_q.prio[i];
         end
      end
      st_d.pres.valid = best_found && (!act_any || best_prio < act_min);
      st_d.pres.num = best_num;
      st_d.pres.prio = best_prio;
   end

   // ---------------------------------------------------------------
   // State register and outputs.
   // ---------------------------------------------------------------

   // The whole state resets to zero: all disabled, idle, priority 0.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from flops.
   assign rdata = st_q.rdata;
   assign core_req = st_q.pres;

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   AST_EN_SET: assert property (
      bus.wr && in_bank(bus.addr, OFS_EN_SET) && word0
      |=> (st_q.en & $past(wmask)) == $past(wmask)
         && (st_q.en & ~$past(wmask)) == ($past(st_q.en) & ~$past(wmask)))
      else $error("enable set write did not act bit for bit");

   AST_EN_CLR: assert property (
      bus.wr && in_bank(bus.addr, OFS_EN_CLR) && word0
      |=> (st_q.en & $past(wmask)) == '0)
      else $error("enable clear write left a bit enabled");

   AST_PEND_SET: assert property (
      bus.wr && in_bank(bus.addr, OFS_PEND_SET) && word0
      |=> (st_q.pend & $past(wmask)) == $past(wmask))
      else $error("set pending write did not pend");

   AST_CLR_KEEPS_ACT: assert property (
      bus.wr && in_bank(bus.addr, OFS_PEND_CLR) && !core_rsp.ack &&
      !core_rsp.done
      |=> st_q.act == $past(st_q.act))
      else $error("clear pending changed active flags");

   AST_LEVEL_HOLD: assert property (
      bus.wr && in_bank(bus.addr, OFS_PEND_CLR) && word0 && !core_rsp.ack
      |=> (st_q.pend & $past(st_q.pend & st_q.level & irq_lines)) ==
          $past(st_q.pend & st_q.level & irq_lines))
      else $error("level line pending lost on clear");

   AST_EDGE_PENDS: assert property (
      (irq_lines & ~st_q.line_prev) != '0
      |=> (st_q.pend & $past(irq_lines & ~st_q.line_prev)) ==
          $past(irq_lines & ~st_q.line_prev))
      else $error("rising request edge did not pend");

   AST_NEVER_DISABLED: assert property (
      st_d.pres.valid |-> st_q.en[best_num[4:0]] && st_q.pend[best_num[4:0]])
      else $error("disabled or idle interrupt presented");

   AST_PRESENT: assert property (
      best_found && !act_any
      |=> core_req.valid ##0 core_req.num == $past(best_num))
      else $error("candidate not presented one cycle later");

   AST_PRIO_LOW_ZERO: assert property (
      bus.rd && in_bank(bus.addr, OFS_PRIO)
      |=> (rdata & PRIO_LOW_NIBBLES) == '0 ##1 rdata == '0 || $past(bus.rd))
      else $error("priority low nibble read nonzero");

   AST_ACTIVE_READ: assert property (
      bus.rd && in_bank(bus.addr, OFS_ACTIVE) && word0
      |=> rdata == $past(st_q.act))
      else $error("active flag read mismatch");

   AST_TRIGGER: assert property (
      bus.wr && bus.addr == OFS_TRIGGER && bus.wdata[8:0] < ID_LIMIT
      |=> st_q.pend[$past(bus.wdata[4:0])])
      else $error("trigger write did not pend");

   AST_RETURN_RESAMPLE: assert property (
      core_rsp.done && core_rsp.done_num < ID_LIMIT &&
      st_q.level[core_rsp.done_num[4:0]] && irq_lines[core_rsp.done_num[4:0]]
      |=> st_q.pend[$past(core_rsp.done_num[4:0])] &&
          !st_q.act[$past(core_rsp.done_num[4:0])])
      else $error("level return did not repend");

endmodule

`default_nettype wire

// file: tb/core_model.sv
// Processor core model that takes offered interrupts and returns them.
`timescale 1ns/10ps
`default_nettype none

module core_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire irq_ctrl_pkg::core_req_s core_req,
   input wire logic arm,
   input wire logic ret,
   input wire logic [8:0] ret_num,
   output var irq_ctrl_pkg::core_rsp_s core_rsp
);
   import irq_ctrl_pkg::*;

   int unsigned wait_n;
   logic armed;

   // One take per arm, after a random stall of up to three cycles.
   // The return number is scrambled between returns so that a stale value
   // is never mistaken for a live one.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         armed <= 1'b0;
         wait_n <= 0;
         core_rsp <= '0;
      end else begin
         core_rsp.ack <= 1'b0;
         core_rsp.done <= ret;
         core_rsp.done_num <= ret ? ret_num : ~core_rsp.done_num;
         if (arm) begin
            armed <= 1'b1;
            wait_n <= $urandom_range(3);
         end else if (armed && core_req.valid === 1'b1) begin
            if (wait_n == 0) begin
               core_rsp.ack <= 1'b1;
               armed <= 1'b0;
            end else begin
               wait_n <= wait_n - 1;
            end
         end
      end
   end
endmodule

`default_nettype wire

// file: tb/nested_irq_controller_tb.sv
// Self-checking bench of the nested interrupt controller.
`timescale 1ns/10ps
`default_nettype none

module nested_irq_controller_tb;
   import irq_ctrl_pkg::*;

   logic mclk, resetn, arm, ret;
   logic [8:0] ret_num;
   logic [31:0] rdata, lines, m, e, got;
   bus_req_s bus;
   core_req_s req;
   core_rsp_s rsp;
   int miscompares, tests_run, n, k;
   logic [PRIO_W-1:0] prio_m [IRQ_COUNT];

   nested_irq_controller u_nested_irq_controller (.mclk(mclk),
      .resetn(resetn), .bus(bus), .rdata(rdata), .irq_lines(lines),
      .core_rsp(rsp), .core_req(req));
   core_model u_core_model (.mclk(mclk), .resetn(resetn), .core_req(req),
      .arm(arm), .ret(ret), .ret_num(ret_num), .core_rsp(rsp));

   // ------------------------------------------------------------
   // Bus cycles, checks and expectations.
   // ------------------------------------------------------------
   task automatic wr(input logic [31:0] a, input logic [31:0] d,
         input logic [3:0] b = 4'hf);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, be: b, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic chk_rd(input logic [31:0] a, input logic [31:0] x);
      @(posedge mclk);
      bus <= '{addr: a, wdata: $urandom, be: 4'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 got = rdata;
      chk(got, x);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, g, x);
      end
   endtask

   // Lowest value wins; strict compare keeps the lowest number on ties.
   function automatic logic [9:0] best(input logic [31:0] cand);
      logic [9:0] r;
      logic [4:0] p;
      r = '0;
      p = 5'h10;
      for (int i = 0; i < IRQ_COUNT; i++) begin
         if (cand[i] && {1'b0, prio_m[i]} < p) begin
            r = {1'b1, 9'(i)};
            p = {1'b0, prio_m[i]};
         end
      end
      return r;
   endfunction

   task automatic take_and_return(input int num, input bit back);
      @(posedge mclk);
      arm <= 1'b1;
      @(posedge mclk);
      arm <= 1'b0;
      repeat (8) @(posedge mclk);
      if (back) begin
         ret <= 1'b1;
         ret_num <= 9'(num);
         @(posedge mclk);
         ret <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d, miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock and hang guard.
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      end_sim();
   end

   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      bus = '0;
      lines = '0;
      arm = 1'b0;
      ret = 1'b0;
      ret_num = '0;
      miscompares = 0;
      tests_run = 0;
      foreach (prio_m[i]) prio_m[i] = '0;
      void'($urandom(50780));
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      chk_rd(OFS_EN_SET, WORD_RST);
      chk_rd(OFS_ACTIVE, WORD_RST);
      wr(32'he000e500, 32'hffffffff);
      chk_rd(32'he000e500, 32'h0);
      chk_rd(OFS_TRIGGER, 32'h0);
      // Enables: zero bits leave state alone, ones set or clear.
      e = $urandom;
      wr(OFS_EN_SET, e);
      wr(OFS_EN_SET, 32'h0);
      chk_rd(OFS_EN_SET, e);
      m = $urandom;
      wr(OFS_EN_CLR, m);
      chk_rd(OFS_EN_CLR, e & ~m);
      wr(OFS_EN_CLR, 32'hffffffff);
      // Pending on disabled lines, set twice, then partly cleared.
      m = $urandom;
      wr(OFS_PEND_SET, m);
      wr(OFS_PEND_SET, m & $urandom);
      chk_rd(OFS_PEND_SET, m);
      chk({31'h0, req.valid}, 32'h0);
      e = $urandom;
      wr(OFS_PEND_CLR, e);
      chk_rd(OFS_PEND_CLR, m & ~e);
      wr(OFS_PEND_CLR, 32'hffffffff);
      // Priority words with random byte lanes.
      for (k = 0; k < 8; k++) begin
         m = $urandom;
         n = $urandom_range(15);
         wr(OFS_PRIO + 32'(4 * k), m, 4'(n));
         for (int j = 0; j < 4; j++) begin
            if (n[j]) prio_m[4 * k + j] = m[8 * j + 4 +: 4];
         end
         chk_rd(OFS_PRIO + 32'(4 * k), {prio_m[4 * k + 3], 4'h0,
            prio_m[4 * k + 2], 4'h0, prio_m[4 * k + 1], 4'h0,
            prio_m[4 * k], 4'h0});
      end
      // Software trigger with junk above the identifier field.
      for (k = 0; k < 4; k++) begin
         n = $urandom_range(IRQ_COUNT - 1);
         wr(OFS_TRIGGER, ($urandom & 32'hfffffe00) | 32'(n));
         chk_rd(OFS_PEND_SET, 32'h1 << n);
         wr(OFS_PEND_CLR, 32'hffffffff);
      end
      // A rising request on a disabled line pends but is never offered.
      n = $urandom_range(IRQ_COUNT - 1);
      @(posedge mclk);
      lines <= 32'h1 << n;
      chk_rd(OFS_PEND_SET, 32'h1 << n);
      chk({31'h0, req.valid}, 32'h0);
      lines <= '0;
      wr(OFS_PEND_CLR, 32'hffffffff);
      // Arbitration, take, clear-pending while active, and return.
      for (k = 0; k < 6; k++) begin
         e = $urandom | 32'h1;
         m = $urandom | 32'h1;
         wr(OFS_EN_SET, e);
         wr(OFS_PEND_SET, m);
         repeat (3) @(posedge mclk);
         #1 got = {22'h0, best(e & m)};
         chk({22'h0, req.valid, req.num}, got);
         chk({28'h0, req.prio}, {28'h0, prio_m[got[4:0]]});
         n = int'(req.num);
         take_and_return(n, 1'b0);
         wr(OFS_PEND_SET, 32'h1 << n);
         chk_rd(OFS_ACTIVE, 32'h1 << n);
         wr(OFS_PEND_CLR, 32'h1 << n);
         chk_rd(OFS_ACTIVE, 32'h1 << n);
         chk_rd(OFS_PEND_SET, m & ~(32'h1 << n));
         // Let the core idle so that no second interrupt is taken.
         repeat (10) @(posedge mclk);
         ret <= 1'b1;
         ret_num <= 9'(n);
         @(posedge mclk);
         ret <= 1'b0;
         repeat (2) @(posedge mclk);
         chk_rd(OFS_ACTIVE, 32'h0);
         wr(OFS_PEND_CLR, 32'hffffffff);
         wr(OFS_EN_CLR, 32'hffffffff);
      end
      // Level-sensitive line seven: clear blocked while high, resampled.
      wr(OFS_LEVEL_SEL, 32'h80);
      lines <= 32'h80;
      wr(OFS_PEND_CLR, 32'h80);
      chk_rd(OFS_PEND_SET, 32'h80);
      lines <= '0;
      wr(OFS_PEND_CLR, 32'h80);
      chk_rd(OFS_PEND_SET, 32'h0);
      lines <= 32'h80;
      wr(OFS_EN_SET, 32'h80);
      take_and_return(7, 1'b1);
      chk_rd(OFS_PEND_SET, 32'h80);
      chk_rd(OFS_ACTIVE, 32'h0);
      end_sim();
   end
endmodule

`default_nettype wire
